//--- inc/irtfs_pkg.sv
// ==========================================================
// Register map, field layout and timing of the iris target block
package irtfs_pkg;

   // ==========================================================
   // Register addresses on the serial port
   localparam logic [5:0] ADDR_FILTER_CFG = 6'h05;
   localparam logic [5:0] ADDR_STROBE_START = 6'h06;
   localparam logic [5:0] ADDR_STROBE_WIDTH = 6'h07;
   localparam logic [5:0] ADDR_CLOSE_START = 6'h08;
   localparam logic [5:0] ADDR_CLOSE_WIDTH = 6'h09;
   localparam logic [5:0] ADDR_STATUS = 6'h1F;
   localparam logic [15:0] REG_RESET = 16'h0000;

   // ==========================================================
   // Field positions and widths
   localparam int CUTOFF_W = 4;
   localparam int BYPASS_BIT = 4;
   localparam int INVERT_BIT = 5;
   localparam int ENABLE_BIT = 15;
   localparam int START_W = 10;
   localparam int SWIDTH_W = 12;
   localparam int CWIDTH_W = 6;
   localparam int STAT_STROBE_BIT = 0;
   localparam int STAT_CLOSE_BIT = 1;
   localparam int STAT_SBUSY_BIT = 2;
   localparam int STAT_CBUSY_BIT = 3;
   localparam int TARGET_W = 10;
   localparam int PID_W = 16;

   // ==========================================================
   // Serial frame: 6-bit address, read flag, spare bit, 16 data bits, LSB first
   localparam logic [4:0] ADDR_BITS = 5'h08;
   localparam logic [4:0] FRAME_BITS = 5'h18;
   localparam int READ_FLAG_BIT = 6;

   // ==========================================================
   // Timing at 100 MHz; step times are num/3.375 us
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned STEP_DEN_X1000 = 3375;
   localparam int unsigned START_STEP_NUM_US = 68;
   localparam int unsigned WIDTH_STEP_NUM_US = 4;
   localparam int unsigned FILT_SAMPLE_NS = 1000;
   localparam logic [11:0] START_STEP_CYC = 12'(
      (START_STEP_NUM_US * 1000000 / STEP_DEN_X1000 + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS);
   localparam logic [11:0] WIDTH_STEP_CYC = 12'(
      (WIDTH_STEP_NUM_US * 1000000 / STEP_DEN_X1000 + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS);
   localparam logic [11:0] FILT_SAMPLE_CYC = 12'(FILT_SAMPLE_NS / CLK_PERIOD_NS);

   typedef enum logic [1:0] {S_IDLE, S_DELAY, S_WIDTH} irtfs_strobe_t;
   typedef enum logic [1:0] {C_IDLE, C_DELAY, C_COUNT, C_TAIL} irtfs_close_t;

endpackage

//--- logic/irtfs_target_filter.sv
`timescale 1ns/1ps
// ==========================================================
// First-order low-pass on the iris target, sampled at 1 MHz
module irtfs_target_filter (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [irtfs_pkg::TARGET_W-1:0] target_in,
   input wire logic [irtfs_pkg::CUTOFF_W-1:0] cutoff_in,
   input wire logic bypass_in,
   output logic [irtfs_pkg::TARGET_W-1:0] target_out
);
   import irtfs_pkg::*;

   typedef struct packed {
      logic [11:0] div;
      logic [25:0] acc;
      logic [TARGET_W-1:0] out;
   } irtfs_filt_t;

   irtfs_filt_t s_r;
   irtfs_filt_t s_nxt;
   logic signed [26:0] diff;
   logic signed [39:0] prod;

   // Gain 2*pi*fc/fs scaled by 65536
   function automatic logic [11:0] coef(input logic [CUTOFF_W-1:0] code);
      unique case (code)
         4'h0: coef = 12'h086;
         4'h1: coef = 12'h10C;
         4'h2: coef = 12'h217;
         4'h3: coef = 12'h42F;
         4'h4: coef = 12'h010;
         4'h5: coef = 12'h015;
         4'h6: coef = 12'h01A;
         4'h7: coef = 12'h021;
         4'h8: coef = 12'h029;
         4'h9: coef = 12'h033;
         4'hA: coef = 12'h042;
         4'hB: coef = 12'h052;
         4'hC: coef = 12'h067;
         default: coef = 12'h086; // Reserved codes fall back to 325 Hz
      endcase
   endfunction

   assign diff = $signed({1'b0, target_in, 16'h0000}) - $signed({1'b0, s_r.acc});
   assign prod = diff * $signed({1'b0, coef(cutoff_in)});

   always_comb begin
      s_nxt = s_r;
      s_nxt.div = (s_r.div == FILT_SAMPLE_CYC - 12'h001) ? 12'h000 : s_r.div + 12'h001;
      if (s_r.div == FILT_SAMPLE_CYC - 12'h001) begin
         s_nxt.acc = 26'($signed({1'b0, s_r.acc}) + $signed(prod[39:16]));
      end
      if (bypass_in) begin
         s_nxt.acc = {target_in, 16'h0000};
         s_nxt.out = target_in;
      end else begin
         s_nxt.out = s_nxt.acc[25:16];
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign target_out = s_r.out;

   AST_FILT_BYPASS: assert property (@(posedge clk_in) disable iff (rst_in)
      bypass_in |=> target_out == $past(target_in)) else $error("bypass not passing target");
   AST_FILT_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
      (!bypass_in && s_r.div != FILT_SAMPLE_CYC - 12'h001) |=> $stable(s_r.acc))
      else $error("filter moved off its sample tick");

endmodule // irtfs_target_filter

//--- logic/irtfs_iris_target_sync.sv
`timescale 1ns/1ps
module irtfs_iris_target_sync (
   input wire logic CORE_CLK_IN,
   input wire logic RST_IN,
   input wire logic SERIAL_CLK_IN,
   input wire logic SERIAL_CS_IN,
   input wire logic SERIAL_DATA_IN,
   output logic SERIAL_DATA_OUT,
   output logic SERIAL_DATA_OE_N_OUT,
   input wire logic VIDEO_VERTICAL_SYNC_IN,
   input wire logic [irtfs_pkg::TARGET_W-1:0] IRIS_TARGET_IN,
   output logic [irtfs_pkg::TARGET_W-1:0] TARGET_FILTERED_OUT,
   input wire logic signed [irtfs_pkg::PID_W-1:0] PID_ACTION_IN,
   output logic signed [irtfs_pkg::PID_W-1:0] PID_ACTION_OUT,
   output logic STROBE_OUT,
   output logic CLOSE_OUT
);
   import irtfs_pkg::*;

   typedef struct packed {
      logic [1:0] vs_sync;
      logic vs_prev;
      logic [1:0] sclk_sync;
      logic sclk_prev;
      logic [1:0] cs_sync;
      logic [1:0] sin_sync;
      logic [4:0] bit_cnt;
      logic [23:0] shift;
      logic rd_mode;
      logic [15:0] rd_shift;
      logic sout;
      logic sout_oe_n;
      logic [CUTOFF_W-1:0] f_cutoff;
      logic f_bypass;
      logic f_invert;
      logic [START_W-1:0] s_start;
      logic [SWIDTH_W-1:0] s_width;
      logic s_en;
      logic [START_W-1:0] c_start;
      logic [CWIDTH_W-1:0] c_width;
      logic c_en;
      logic [START_W-1:0] c_start_sh;
      logic [CWIDTH_W-1:0] c_width_sh;
      irtfs_strobe_t st;
      logic [SWIDTH_W-1:0] s_cnt;
      logic [11:0] s_div;
      irtfs_close_t c_st;
      logic [START_W-1:0] c_cnt;
      logic [11:0] c_div;
      logic [CWIDTH_W-1:0] c_rises;
      logic strobe_q;
      logic close_q;
      logic signed [PID_W-1:0] pid_q;
   } irtfs_state_t;

   irtfs_state_t s_r;
   irtfs_state_t s_nxt;
   logic vs_rise;
   logic vs_fall;
   logic sclk_rise;
   logic sclk_fall;
   logic strobe_go;
   logic close_go;
   logic [7:0] rd_addr;
   logic [15:0] rd_word;
   logic [7:0] wr_addr;
   logic [15:0] wr_data;

   // ==========================================================
   // Edge detection on synchronised pins
   assign vs_rise = s_r.vs_sync[1] & ~s_r.vs_prev;
   assign vs_fall = ~s_r.vs_sync[1] & s_r.vs_prev;
   assign sclk_rise = s_r.sclk_sync[1] & ~s_r.sclk_prev;
   assign sclk_fall = ~s_r.sclk_sync[1] & s_r.sclk_prev;
   assign strobe_go = s_r.s_en && (s_r.s_start != '0) && (s_r.s_width != '0);
   assign close_go = s_r.c_en && (s_r.c_start != '0) && (s_r.c_width != '0);
   assign rd_addr = {s_r.sin_sync[1], s_r.shift[23:17]};
   // Frame as it stands after the shift of the current bit, read from registers only
   assign wr_addr = s_r.shift[8:1];
   assign wr_data = {s_r.sin_sync[1], s_r.shift[23:9]};

   // ==========================================================
   // Register read mux
   always_comb begin
      rd_word = REG_RESET;
      unique case (rd_addr[5:0])
         ADDR_FILTER_CFG: begin
            rd_word[CUTOFF_W-1:0] = s_r.f_cutoff;
            rd_word[BYPASS_BIT] = s_r.f_bypass;
            rd_word[INVERT_BIT] = s_r.f_invert;
         end
         ADDR_STROBE_START: rd_word[START_W-1:0] = s_r.s_start;
         ADDR_STROBE_WIDTH: begin
            rd_word[SWIDTH_W-1:0] = s_r.s_width;
            rd_word[ENABLE_BIT] = s_r.s_en;
         end
         ADDR_CLOSE_START: rd_word[START_W-1:0] = s_r.c_start;
         ADDR_CLOSE_WIDTH: begin
            rd_word[CWIDTH_W-1:0] = s_r.c_width;
            rd_word[ENABLE_BIT] = s_r.c_en;
         end
         ADDR_STATUS: begin
            rd_word[STAT_STROBE_BIT] = s_r.strobe_q;
            rd_word[STAT_CLOSE_BIT] = s_r.close_q;
            rd_word[STAT_SBUSY_BIT] = (s_r.st != S_IDLE);
            rd_word[STAT_CBUSY_BIT] = (s_r.c_st != C_IDLE);
         end
         default: rd_word = REG_RESET;
      endcase
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.vs_sync = {s_r.vs_sync[0], VIDEO_VERTICAL_SYNC_IN};
      s_nxt.vs_prev = s_r.vs_sync[1];
      s_nxt.sclk_sync = {s_r.sclk_sync[0], SERIAL_CLK_IN};
      s_nxt.sclk_prev = s_r.sclk_sync[1];
      s_nxt.cs_sync = {s_r.cs_sync[0], SERIAL_CS_IN};
      s_nxt.sin_sync = {s_r.sin_sync[0], SERIAL_DATA_IN};

      // ==========================================================
      // Serial port: shift on clock rise, drive read data on clock fall
      if (!s_r.cs_sync[1]) begin
         s_nxt.bit_cnt = 5'h00;
         s_nxt.rd_mode = 1'b0;
         s_nxt.sout_oe_n = 1'b1;
      end else if (sclk_rise && s_r.bit_cnt != FRAME_BITS) begin
         s_nxt.shift = {s_r.sin_sync[1], s_r.shift[23:1]};
         s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
         if (s_nxt.bit_cnt == ADDR_BITS && s_nxt.shift[16 + READ_FLAG_BIT]) begin
            s_nxt.rd_mode = 1'b1;
            s_nxt.rd_shift = rd_word;
         end
         if (s_nxt.bit_cnt == FRAME_BITS && !s_r.rd_mode) begin
            unique case (wr_addr[5:0])
               ADDR_FILTER_CFG: begin
                  s_nxt.f_cutoff = wr_data[CUTOFF_W-1:0];
                  s_nxt.f_bypass = wr_data[BYPASS_BIT];
                  s_nxt.f_invert = wr_data[INVERT_BIT];
               end
               ADDR_STROBE_START: s_nxt.s_start = wr_data[START_W-1:0];
               ADDR_STROBE_WIDTH: begin
                  s_nxt.s_width = wr_data[SWIDTH_W-1:0];
                  s_nxt.s_en = wr_data[ENABLE_BIT];
               end
               ADDR_CLOSE_START: s_nxt.c_start = wr_data[START_W-1:0];
               ADDR_CLOSE_WIDTH: begin
                  s_nxt.c_width = wr_data[CWIDTH_W-1:0];
                  s_nxt.c_en = wr_data[ENABLE_BIT];
               end
               default: s_nxt.bit_cnt = FRAME_BITS;
            endcase
         end
      end else if (sclk_fall && s_r.rd_mode) begin
         s_nxt.sout = s_r.rd_shift[0];
         s_nxt.rd_shift = {1'b0, s_r.rd_shift[15:1]};
         s_nxt.sout_oe_n = 1'b0;
      end

      // ==========================================================
      // Strobe pulse: delay steps then width steps
      unique case (s_r.st)
         S_IDLE: begin
         end
         S_DELAY: begin
            s_nxt.s_div = s_r.s_div + 12'h001;
            if (s_r.s_div == START_STEP_CYC - 12'h001) begin
               s_nxt.s_div = 12'h000;
               s_nxt.s_cnt = s_r.s_cnt - 12'h001;
               if (s_r.s_cnt == 12'h001) begin
                  s_nxt.st = S_WIDTH;
                  s_nxt.s_cnt = s_r.s_width;
               end
            end
         end
         S_WIDTH: begin
            s_nxt.s_div = s_r.s_div + 12'h001;
            if (s_r.s_div == WIDTH_STEP_CYC - 12'h001) begin
               s_nxt.s_div = 12'h000;
               s_nxt.s_cnt = s_r.s_cnt - 12'h001;
               if (s_r.s_cnt == 12'h001) begin
                  s_nxt.st = S_IDLE;
               end
            end
         end
      endcase
      if (vs_rise && strobe_go) begin
         s_nxt.st = S_DELAY;
         s_nxt.s_cnt = SWIDTH_W'(s_r.s_start);
         s_nxt.s_div = 12'h000;
      end
      if (!strobe_go) begin
         s_nxt.st = S_IDLE;
      end
      s_nxt.strobe_q = (s_nxt.st == S_WIDTH);

      // ==========================================================
      // Full-close pulse: delay steps, then counted sync rises
      unique case (s_r.c_st)
         C_IDLE: begin
            s_nxt.c_start_sh = s_r.c_start;
            s_nxt.c_width_sh = s_r.c_width;
            if (vs_rise && close_go) begin
               s_nxt.c_st = C_DELAY;
               s_nxt.c_cnt = s_r.c_start;
               s_nxt.c_div = 12'h000;
            end
         end
         C_DELAY: begin
            s_nxt.c_div = s_r.c_div + 12'h001;
            if (s_r.c_div == START_STEP_CYC - 12'h001) begin
               s_nxt.c_div = 12'h000;
               s_nxt.c_cnt = s_r.c_cnt - 10'h001;
               if (s_r.c_cnt == 10'h001) begin
                  s_nxt.c_st = C_COUNT;
                  s_nxt.c_rises = 6'h00;
               end
            end
         end
         C_COUNT: begin
            if (vs_rise) begin
               s_nxt.c_rises = s_r.c_rises + 6'h01;
               if (s_nxt.c_rises == s_r.c_width_sh) begin
                  s_nxt.c_st = C_TAIL;
               end
            end
         end
         C_TAIL: begin
            if (vs_fall) begin
               s_nxt.c_st = C_IDLE;
            end
         end
      endcase
      if (!s_r.c_en) begin
         s_nxt.c_st = C_IDLE;
      end
      s_nxt.close_q = (s_nxt.c_st == C_COUNT) || (s_nxt.c_st == C_TAIL);

      // ==========================================================
      // Control polarity, saturating the one value with no negative
      if (s_r.f_invert) begin
         s_nxt.pid_q = (PID_ACTION_IN == 16'sh8000) ? 16'sh7FFF : -PID_ACTION_IN;
      end else begin
         s_nxt.pid_q = PID_ACTION_IN;
      end
   end

   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         s_r <= '0;
         s_r.sout_oe_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   irtfs_target_filter irtfs_target_filter_inst (
      .clk_in(CORE_CLK_IN),
      .rst_in(RST_IN),
      .target_in(IRIS_TARGET_IN),
      .cutoff_in(s_r.f_cutoff),
      .bypass_in(s_r.f_bypass),
      .target_out(TARGET_FILTERED_OUT)
   );

   assign SERIAL_DATA_OUT = s_r.sout;
   assign SERIAL_DATA_OE_N_OUT = s_r.sout_oe_n;
   assign STROBE_OUT = s_r.strobe_q;
   assign CLOSE_OUT = s_r.close_q;
   assign PID_ACTION_OUT = s_r.pid_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (RST_IN);

   AST_STROBE_SUPPRESS: assert property (!strobe_go |=> !STROBE_OUT)
      else $error("strobe active with zero setting");
   AST_STROBE_GATE: assert property ($fell(s_r.s_en) |-> ##1 !STROBE_OUT[*2])
      else $error("strobe not gated by enable");
   AST_STROBE_LOAD: assert property ((s_r.st == S_IDLE && vs_rise && strobe_go)
      |=> (s_r.st == S_DELAY && s_r.s_cnt == SWIDTH_W'($past(s_r.s_start))
      && s_r.s_div == 12'h000)) else $error("strobe delay not loaded");
   AST_STROBE_WIDTH: assert property ($rose(STROBE_OUT)
      |-> s_r.s_cnt == s_r.s_width && s_r.s_div == 12'h000)
      else $error("strobe width not loaded at delay end");
   AST_STROBE_STEP: assert property ((s_r.st == S_WIDTH
      && s_r.s_div == WIDTH_STEP_CYC - 12'h001 && s_r.s_cnt == 12'h001 && !vs_rise && strobe_go)
      |=> !STROBE_OUT) else $error("strobe width overran");
   AST_CLOSE_HOLD: assert property (s_r.c_st != C_IDLE
      |=> $stable(s_r.c_start_sh) && $stable(s_r.c_width_sh))
      else $error("close setting changed mid-count");
   AST_CLOSE_END: assert property ((s_r.c_st == C_TAIL && vs_fall) |=> !CLOSE_OUT)
      else $error("close pulse not ended at sync fall");
   AST_CLOSE_SUPPRESS: assert property ((s_r.c_st == C_IDLE && !close_go)
      |=> s_r.c_st == C_IDLE ##1 !CLOSE_OUT) else $error("close started with zero");
   AST_CLOSE_GATE: assert property (!s_r.c_en |=> !CLOSE_OUT)
      else $error("close not gated by enable");
   AST_CLOSE_DELAY: assert property ((s_r.c_st == C_DELAY
      && s_r.c_div == START_STEP_CYC - 12'h001 && s_r.c_cnt == 10'h001 && s_r.c_en)
      |=> CLOSE_OUT && s_r.c_rises == 6'h00) else $error("close delay end mistimed");
   AST_PID_SIGN: assert property (($past(s_r.f_invert)
      && $past(PID_ACTION_IN) != 16'sh8000) |-> PID_ACTION_OUT == -$past(PID_ACTION_IN))
      else $error("polarity not inverted");

   COV_STROBE: cover property ($fell(STROBE_OUT));
   COV_CLOSE: cover property ($fell(CLOSE_OUT));
   COV_WRITE: cover property (s_r.bit_cnt == FRAME_BITS && !s_r.rd_mode);
   COV_READ: cover property (s_r.rd_mode && !SERIAL_DATA_OE_N_OUT);

endmodule // irtfs_iris_target_sync

//--- bench/irtfs_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Camera host: drives vertical sync and times both pulses
module irtfs_host_model #(
   parameter int PERIOD = 2500,
   parameter int HIGH = 300
) (
   input wire logic clk_in,
   input wire logic run_in,
   input wire logic clr_in,
   input wire logic strobe_in,
   input wire logic close_in,
   output logic vsync_out,
   output int s_ofs_out,
   output int s_wid_out,
   output int s_cnt_out,
   output int c_ofs_out,
   output int c_wid_out,
   output int c_cnt_out
);
   int ph = 0;
   int since = 0;
   int sw = 0;
   int cw = 0;
   logic s_q = 1'b0;
   logic c_q = 1'b0;

   initial vsync_out = 1'b0;

   // Sync stands low between runs; offsets count from the last sync rise
   always @(posedge clk_in) begin
      ph <= run_in ? (ph + 1) % PERIOD : 0;
      vsync_out <= run_in && (ph < HIGH);
      since <= (run_in && ph == 0) ? 0 : since + 1;
      s_q <= strobe_in;
      c_q <= close_in;
      sw <= strobe_in ? sw + 1 : 0;
      cw <= close_in ? cw + 1 : 0;
      if (strobe_in && !s_q) s_ofs_out <= since;
      if (close_in && !c_q) c_ofs_out <= since;
      if (!strobe_in && s_q) begin
         s_wid_out <= sw;
         s_cnt_out <= s_cnt_out + 1;
      end
      if (!close_in && c_q) begin
         c_wid_out <= cw;
         c_cnt_out <= c_cnt_out + 1;
      end
      if (clr_in) begin
         s_cnt_out <= 0;
         c_cnt_out <= 0;
      end
   end
endmodule // irtfs_host_model

//--- bench/test_irtfs_iris_target_sync.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the iris target and sync pulse block
module test_irtfs_iris_target_sync;
   import irtfs_pkg::*;
   localparam int P = 2500;
   localparam int H = 300;
   localparam int ST = int'(START_STEP_CYC);
   localparam int WS = int'(WIDTH_STEP_CYC);
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sclk = 1'b0;
   logic cs = 1'b0;
   logic sdi = 1'b0;
   logic run = 1'b0;
   logic clr = 1'b0;
   logic sdo, oe_n, vs, strobe, close;
   logic [TARGET_W-1:0] tgt = '0;
   logic [TARGET_W-1:0] tgt_f;
   logic signed [PID_W-1:0] pid = '0;
   logic signed [PID_W-1:0] pid_o;
   int s_ofs, s_wid, s_cnt, c_ofs, c_wid, c_cnt;
   int num_errors = 0;
   int cmp_count = 0;
   logic [15:0] rdat;
   logic [TARGET_W-1:0] v [0:13];
   int fq [0:12] = '{325, 650, 1300, 2600, 40, 50, 63, 80, 100, 125, 160, 200, 250};
   logic [5:0] adr [0:6] = '{ADDR_FILTER_CFG, ADDR_STROBE_START, ADDR_STROBE_WIDTH,
      ADDR_CLOSE_START, ADDR_CLOSE_WIDTH, ADDR_STATUS, 6'h10};
   logic [15:0] msk [0:6] = '{16'h003F, 16'h03FF, 16'h8FFF, 16'h03FF, 16'h803F, 16'h0, 16'h0};
   logic signed [15:0] pv [0:3] = '{16'sh0001, 16'sh7FFF, 16'sh8000, 16'shFF00};
   logic [15:0] cfg [0:2][0:3] = '{'{16'h0000, 16'h8003, 16'h0000, 16'h8002},
      '{16'h0001, 16'h0003, 16'h0001, 16'h0002}, '{16'h0001, 16'h8000, 16'h0001, 16'h8000}};

   always #5 clk = ~clk;

   irtfs_iris_target_sync irtfs_iris_target_sync_inst (
      .CORE_CLK_IN(clk), .RST_IN(rst), .SERIAL_CLK_IN(sclk), .SERIAL_CS_IN(cs),
      .SERIAL_DATA_IN(sdi), .SERIAL_DATA_OUT(sdo), .SERIAL_DATA_OE_N_OUT(oe_n),
      .VIDEO_VERTICAL_SYNC_IN(vs), .IRIS_TARGET_IN(tgt), .TARGET_FILTERED_OUT(tgt_f),
      .PID_ACTION_IN(pid), .PID_ACTION_OUT(pid_o), .STROBE_OUT(strobe), .CLOSE_OUT(close)
   );

   irtfs_host_model #(.PERIOD(P), .HIGH(H)) irtfs_host_model_inst (
      .clk_in(clk), .run_in(run), .clr_in(clr), .strobe_in(strobe), .close_in(close),
      .vsync_out(vs), .s_ofs_out(s_ofs), .s_wid_out(s_wid), .s_cnt_out(s_cnt),
      .c_ofs_out(c_ofs), .c_wid_out(c_wid), .c_cnt_out(c_cnt)
   );

   // ==========================================================
   // Checks and bus tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chkr(input int got, input int lo, input int hi);
      cmp_count++;
      if (got < lo || got > hi) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h to %h", $time, got, lo, hi);
      end
   endtask

   // One 24-bit frame, LSB first; read bits are taken just before each rise
   task automatic xfer(input logic [5:0] a, input logic r, input logic [15:0] d);
      logic [23:0] f;
      f = {d, 1'b0, r, a};
      @(posedge clk) cs <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 24; i++) begin
         @(posedge clk) sdi <= f[i];
         repeat (6) @(posedge clk);
         if (i >= 8) rdat[i-8] = sdo;
         @(posedge clk) sclk <= 1'b1;
         repeat (5) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (6) @(posedge clk);
      if (r) chk(16'(oe_n), 16'h0000);
      cs <= 1'b0;
      repeat (6) @(posedge clk);
   endtask

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      xfer(a, 1'b0, d);
   endtask

   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      xfer(a, 1'b1, 16'h0000);
      chk(rdat, e);
   endtask

   task automatic reset_dut;
      @(posedge clk) rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic start_run;
      @(posedge clk) clr <= 1'b1;
      @(posedge clk) clr <= 1'b0;
      run <= 1'b1;
   endtask

   task automatic frames(input int n);
      start_run();
      repeat (n * P) @(posedge clk);
      run <= 1'b0;
      repeat (10) @(posedge clk);
   endtask

   task automatic wait_close(input int k);
      for (int n = 0; n < 8 * P && c_cnt < k; n++) @(posedge clk);
   endtask

   task automatic summarize;
      if (num_errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      #900_000;
      num_errors++;
      summarize();
   end

   // ==========================================================
   // Test sequence
   initial begin
      reset_dut();
      chk({13'h0, strobe, close, oe_n}, 16'h0001);
      for (int k = 0; k < 7; k++) begin
         rd(adr[k], 16'h0000);
         wr(adr[k], 16'hFFFF);
         rd(adr[k], msk[k]);
      end
      for (int inv = 0; inv < 2; inv++) begin
         wr(ADDR_FILTER_CFG, 16'(inv << INVERT_BIT));
         for (int j = 0; j < 4; j++) begin
            @(posedge clk) pid <= pv[j];
            @(posedge clk);
            #1 chk(pid_o, inv == 0 ? pv[j] : (pv[j] == 16'sh8000 ? 16'sh7FFF : -pv[j]));
         end
      end
      wr(ADDR_FILTER_CFG, 16'(1 << BYPASS_BIT));
      @(posedge clk) tgt <= 10'h2A5;
      @(posedge clk);
      #1 chk(16'(tgt_f), 16'h02A5);
      @(posedge clk) tgt <= '0;
      for (int c = 0; c < 14; c++) begin
         reset_dut();
         wr(ADDR_FILTER_CFG, 16'(c));
         @(posedge clk) tgt <= 10'h3FF;
         repeat (1000) @(posedge clk);
         v[c] = tgt_f;
         tgt <= '0;
      end
      for (int i = 0; i < 13; i++)
         for (int j = 0; j < 13; j++)
            if (fq[i] < fq[j]) chk(16'(v[i] <= v[j]), 16'h0001);
      chk(16'(v[4] < v[3]), 16'h0001);
      chk(16'(v[3] < 10'h3FF), 16'h0001);
      chk(16'(v[13]), 16'(v[0]));
      reset_dut();
      wr(ADDR_STROBE_START, 16'h0001);
      wr(ADDR_STROBE_WIDTH, 16'h8003);
      frames(2);
      chkr(s_cnt, 2, 2);
      chkr(s_ofs, ST + 2, ST + 7);
      chkr(s_wid, 3 * WS, 3 * WS);
      wr(ADDR_CLOSE_START, 16'h0001);
      wr(ADDR_CLOSE_WIDTH, 16'h8002);
      start_run();
      for (int n = 0; n < P && close !== 1'b1; n++) @(posedge clk);
      rd(ADDR_STATUS, 16'h000F);
      wr(ADDR_CLOSE_WIDTH, 16'h8005);
      wait_close(1);
      chkr(c_ofs, ST + 2, ST + 7);
      chkr(c_ofs + c_wid, 2 * P + H + 2, 2 * P + H + 8);
      wait_close(2);
      run <= 1'b0;
      chkr(c_ofs + c_wid, 5 * P + H + 2, 5 * P + H + 8);
      for (int k = 0; k < 3; k++) begin
         for (int r = 0; r < 4; r++) wr(adr[r + 1], cfg[k][r]);
         frames(2);
         chkr(s_cnt + c_cnt, 0, 0);
      end
      summarize();
   end
endmodule // test_irtfs_iris_target_sync
